// ---- tbsd_defines.svh ----
// Purpose: shared constants of the type b attrib select link
// Assumes: included by bare name, definitions only
// Notes: times are in units of 1/fs; cycle counts derive from the clock
`ifndef TBSD_DEFINES_SVH
`define TBSD_DEFINES_SVH

// frame layout
`define TBSD_CMD_ATTRIB 8'h1d
`define TBSD_INF_MATCH 8'hf4
`define TBSD_HDR_LEN 9
`define TBSD_F4_LEN 5
`define TBSD_BUF_DEPTH 16

// atqb protocol info byte 3 fields
`define TBSD_ADC_ARBITRARY 2'b00
`define TBSD_ADC_COMPRESSED 2'b01
`define TBSD_FO_NAD_BIT 1
`define TBSD_FO_CID_BIT 0
`define TBSD_PROTO_TYPE 4'h1
`define TBSD_FWI_DEFAULT 4'h4

// param1 field positions
`define TBSD_P1_SOF_BIT 2
`define TBSD_P1_EOF_BIT 3
`define TBSD_P1_TR1_LSB 4
`define TBSD_P1_TR0_LSB 6
`define TBSD_CID_RFU 4'hf
`define TBSD_PCB_CID_BIT 3

// timing: fs is the subcarrier, fc/16 with fc at 13.56 MHz
`define TBSD_CLK_HZ 40000000
`define TBSD_FS_HZ 847500
`define TBSD_TR0_LONG_FS 48
`define TBSD_TR0_SHORT_FS 16
`define TBSD_TR1_LONG_FS 64
`define TBSD_TR1_SHORT_FS 16
`define TBSD_FS_CYC(n) \
  ((64'(n) * `TBSD_CLK_HZ + `TBSD_FS_HZ - 1) / `TBSD_FS_HZ)
`define TBSD_RSP_WAIT_CYC 16384

// reader register offsets (byte addresses)
`define TBSD_REG_CTRL 8'h00
`define TBSD_REG_PUPI 8'h04
`define TBSD_REG_PARAM 8'h08
`define TBSD_REG_APPD 8'h0c
`define TBSD_REG_STAT 8'h10
`define TBSD_CTRL_START_BIT 0
`define TBSD_CTRL_F4_BIT 1
`define TBSD_CTRL_BADCRC_BIT 2
`define TBSD_CTRL_RESET 32'h0000_0000

`endif

// ---- tbsd_pkg.sv ----
// Purpose: types shared by both ends of the attrib link
// Assumes: nothing beyond the defines header
// Notes: state codes are written out
package tbsd_pkg;

  // card side selection state
  typedef enum logic [1:0] {
    tbsd_ready = 2'b00,
    tbsd_active = 2'b01,
    tbsd_wait = 2'b10,
    tbsd_send = 2'b11
  } tbsd_card_state_t;

  // reader side transfer state
  typedef enum logic [1:0] {
    tbsd_r_idle = 2'b00,
    tbsd_r_send = 2'b01,
    tbsd_r_wait = 2'b10
  } tbsd_rdr_state_t;

endpackage : tbsd_pkg

// ---- tbsd_link_if.sv ----
// Purpose: byte-level contactless link between reader and card
// Assumes: framing and crc_b are done outside; crc result comes with last
// Notes: one byte per valid cycle, no back-pressure
`timescale 1ns/1ps
interface tbsd_link_if;
  // reader to card
  logic cmd_valid;
  logic [7:0] cmd_data;
  logic cmd_last;
  logic cmd_crc_ok;
  // card to reader
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_last;

  modport card (
    input cmd_valid, cmd_data, cmd_last, cmd_crc_ok,
    output rsp_valid, rsp_data, rsp_last
  );
  modport reader (
    output cmd_valid, cmd_data, cmd_last, cmd_crc_ok,
    input rsp_valid, rsp_data, rsp_last
  );
endinterface : tbsd_link_if

// ---- tbsd_frame_buf.sv ----
// Purpose: collect the bytes of one received frame
// Assumes: bytes arrive one per valid cycle, last marks the end
// Notes: done pulses one cycle after last; excess bytes set overflow
`timescale 1ns/1ps
`include "tbsd_defines.svh"
module tbsd_frame_buf #(
  parameter int DEPTH = `TBSD_BUF_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte stream
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  input wire logic crc_ok_i,
  // collected frame
  output logic done_o,
  output logic ok_o,
  output logic [5:0] len_o,
  output logic [DEPTH*8-1:0] bytes_o
);
  logic [7:0] mem [DEPTH];
  logic [5:0] cnt;
  logic ovf;
  wire logic fits = (cnt < 6'(DEPTH));
  wire logic [5:0] next_cnt = cnt + 6'd1;

  // store bytes and count them; a frame closes on last
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= 6'd0;
      ovf <= 1'b0;
      done_o <= 1'b0;
      ok_o <= 1'b0;
      len_o <= 6'd0;
    end
    else
    begin
      done_o <= valid_i & last_i;
      if (valid_i)
      begin
        if (fits)
          mem[cnt[$clog2(DEPTH)-1:0]] <= data_i;
        if (last_i)
        begin
          len_o <= next_cnt;
          ok_o <= crc_ok_i & fits & ~ovf;
          cnt <= 6'd0;
          ovf <= 1'b0;
        end
        else
        begin
          cnt <= fits ? next_cnt : cnt;
          ovf <= ovf | ~fits;
        end
      end
    end
  end

  // flatten for the decoder
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
      bytes_o[i*8 +: 8] = mem[i];
  end
endmodule : tbsd_frame_buf

// ---- tbsd_card.sv ----
// Purpose: card end; advertises its atqb option byte, decodes attrib,
//   decides on the answer and on entry to the active state
// Assumes: the framer strips sof/eof and checks crc_b, reporting it
//   with the last byte; reset is applied at field entry
// Notes: the answer holds one byte; the framer appends crc_b
// Operation
// - advertise two-bit application data coding
// - advertise independent nad and cid option bits
// - report arbitrary coding and cid support
// - attrib is 1d, id, four params, inf
// - selected only when identifier equals own pupi
// - once active, accept frames with own cid
// - param1 b3/b4 release sof and eof
// - reader keeps reserved parameter bits zero
// - param1 b8-b7 sets minimum tr0 delay
// - param1 b6-b5 sets minimum tr1 delay
// - param2 low nibble gives reader frame size
// - param2 b6-b5 select reader-to-card rate
// - param2 b8-b7 select card-to-reader rate
// - param3 confirms protocol, upper nibble zero
// - param4 carries cid zero to fourteen
// - without cid support return cid zero
// - always succeed on attrib without inf; code refuses it on bad param3 or param4, e.g. cid 15
// - f4 check matches application data
// - f4 answer carries no higher-layer bytes
// - no inf: answer and go active
// - other inf: silent, stay ready-declared
// - answer only matching pupi and good crc
// - answer byte is mbli and cid
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "tbsd_defines.svh"
module tbsd_card
  import tbsd_pkg::*;
#(
  parameter bit NAD_SUP = 1'b0,
  parameter bit CID_SUP = 1'b1,
  parameter logic [3:0] MBLI = 4'h0,
  parameter logic [3:0] FWI = `TBSD_FWI_DEFAULT,
  parameter int TR0_DEF_CYC = 64,
  parameter int TR1_DEF_CYC = 64
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to the reader
  tbsd_link_if.card link,
  // card identity
  input wire logic [31:0] pupi_i,
  input wire logic [31:0] app_data_i,
  // advertised and negotiated settings
  output logic [7:0] atqb_info_o,
  output tbsd_card_state_t state_o,
  output logic [3:0] cid_o,
  output logic sof_opt_o,
  output logic eof_opt_o,
  output logic [1:0] pcd_rate_o,
  output logic [1:0] picc_rate_o,
  output logic [8:0] fsd_bytes_o,
  // accepted higher-layer frame while active
  output logic hl_frame_o
);
  localparam int DEPTH = `TBSD_BUF_DEPTH;
  localparam int TR0_L = int'(`TBSD_FS_CYC(`TBSD_TR0_LONG_FS));
  localparam int TR0_S = int'(`TBSD_FS_CYC(`TBSD_TR0_SHORT_FS));
  localparam int TR1_L = int'(`TBSD_FS_CYC(`TBSD_TR1_LONG_FS));
  localparam int TR1_S = int'(`TBSD_FS_CYC(`TBSD_TR1_SHORT_FS));

  // frame size code to bytes; reserved codes give zero
  function automatic logic [8:0] fsd_of(input logic [3:0] code);
    case (code)
      4'h0: fsd_of = 9'd16;
      4'h1: fsd_of = 9'd24;
      4'h2: fsd_of = 9'd32;
      4'h3: fsd_of = 9'd40;
      4'h4: fsd_of = 9'd48;
      4'h5: fsd_of = 9'd64;
      4'h6: fsd_of = 9'd96;
      4'h7: fsd_of = 9'd128;
      4'h8: fsd_of = 9'd256;
      default: fsd_of = 9'd0;
    endcase
  endfunction : fsd_of

  // delay code to cycles; the reserved code falls back to default
  function automatic logic [13:0] dly_of(input logic [1:0] code,
      input int def_c, input int long_c, input int short_c);
    case (code)
      2'b01: dly_of = 14'(long_c);
      2'b10: dly_of = 14'(short_c);
      default: dly_of = 14'(def_c);
    endcase
  endfunction : dly_of

  // bytes arrive most significant first; rebuild the 32-bit word
  function automatic logic [31:0] word_of(input logic [31:0] w);
    word_of = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : word_of

  logic fr_done;
  logic fr_ok;
  logic [5:0] fr_len;
  logic [DEPTH*8-1:0] fr_bytes;
  tbsd_card_state_t state;
  logic [13:0] wait_cnt;
  logic [7:0] answer;

  tbsd_frame_buf #(.DEPTH(DEPTH)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .valid_i(link.cmd_valid),
    .data_i(link.cmd_data),
    .last_i(link.cmd_last),
    .crc_ok_i(link.cmd_crc_ok),
    .done_o(fr_done),
    .ok_o(fr_ok),
    .len_o(fr_len),
    .bytes_o(fr_bytes)
  );

  // attrib field split
  wire logic [7:0] b_cmd = fr_bytes[7:0];
  wire logic [31:0] b_id = word_of(fr_bytes[39:8]);
  wire logic [7:0] p1 = fr_bytes[47:40];
  wire logic [7:0] p2 = fr_bytes[55:48];
  wire logic [7:0] p3 = fr_bytes[63:56];
  wire logic [7:0] p4 = fr_bytes[71:64];
  wire logic [7:0] inf0 = fr_bytes[79:72];
  wire logic [31:0] inf_appd = word_of(fr_bytes[111:80]);
  wire logic [5:0] inf_len = fr_len - 6'(`TBSD_HDR_LEN);

  // attrib qualification
  wire logic is_attrib = fr_ok && b_cmd == `TBSD_CMD_ATTRIB
    && fr_len >= 6'(`TBSD_HDR_LEN);
  wire logic id_match = (b_id == pupi_i);
  wire logic par_ok = p3[7:4] == 4'h0 && p3[3:0] == `TBSD_PROTO_TYPE
    && p4[7:4] == 4'h0 && p4[3:0] != `TBSD_CID_RFU;
  wire logic no_inf = (inf_len == 6'd0);
  wire logic f4_ok = inf_len == 6'(`TBSD_F4_LEN)
    && inf0 == `TBSD_INF_MATCH && inf_appd == app_data_i;
  wire logic take = fr_done && is_attrib && id_match && par_ok
    && (no_inf || f4_ok);
  wire logic [3:0] new_cid = CID_SUP ? p4[3:0] : 4'h0;

  // higher-layer frame addressed to this card while active
  wire logic hl_hit = fr_done && fr_ok && state == tbsd_active
    && (fr_bytes[`TBSD_PCB_CID_BIT] ? fr_bytes[11:8] == cid_o
        : cid_o == 4'h0);

  // guard before the answer: tr0 then tr1
  wire logic [13:0] tr_cyc =
    dly_of(p1[`TBSD_P1_TR0_LSB +: 2], TR0_DEF_CYC, TR0_L, TR0_S)
    + dly_of(p1[`TBSD_P1_TR1_LSB +: 2], TR1_DEF_CYC, TR1_L, TR1_S);

  // option byte: fwi, adc, fo
  wire logic [7:0] next_info = {FWI, `TBSD_ADC_ARBITRARY,
    NAD_SUP, CID_SUP};

  // selection state machine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= tbsd_ready;
      wait_cnt <= 14'd0;
      answer <= 8'h00;
    end
    else
    begin
      case (state)
        tbsd_ready:
          if (take)
          begin
            state <= tbsd_wait;
            wait_cnt <= tr_cyc;
            answer <= {MBLI, new_cid};
          end
        tbsd_wait:
          if (wait_cnt <= 14'd1)
            state <= tbsd_send;
          else
            wait_cnt <= wait_cnt - 14'd1;
        tbsd_send:
          state <= tbsd_active;
        tbsd_active:
          state <= tbsd_active;
        default:
          state <= tbsd_ready;
      endcase
    end
  end

  // negotiated settings, latched when the card is taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cid_o <= 4'h0;
      sof_opt_o <= 1'b0;
      eof_opt_o <= 1'b0;
      pcd_rate_o <= 2'b00;
      picc_rate_o <= 2'b00;
      fsd_bytes_o <= 9'd0;
    end
    else if (state == tbsd_ready && take)
    begin
      cid_o <= new_cid;
      sof_opt_o <= p1[`TBSD_P1_SOF_BIT];
      eof_opt_o <= p1[`TBSD_P1_EOF_BIT];
      pcd_rate_o <= p2[5:4];
      picc_rate_o <= p2[7:6];
      fsd_bytes_o <= fsd_of(p2[3:0]);
    end
  end

  // answer byte out and status registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      link.rsp_valid <= 1'b0;
      link.rsp_data <= 8'h00;
      link.rsp_last <= 1'b0;
      atqb_info_o <= 8'h00;
      state_o <= tbsd_ready;
      hl_frame_o <= 1'b0;
    end
    else
    begin
      link.rsp_valid <= (state == tbsd_send);
      link.rsp_last <= (state == tbsd_send);
      link.rsp_data <= (state == tbsd_send) ? answer : 8'h00;
      atqb_info_o <= next_info;
      state_o <= state;
      hl_frame_o <= hl_hit;
    end
  end
endmodule : tbsd_card

// ---- tbsd_reader.sv ----
// Purpose: reader end; sends one attrib built from registers and
//   reports the card's answer
// Assumes: classic wishbone slave, answers one cycle after the strobe
// Notes: reserved parameter bits are forced to zero on the link
`timescale 1ns/1ps
`include "tbsd_defines.svh"
module tbsd_reader
  import tbsd_pkg::*;
#(
  parameter int RSP_WAIT_CYC = `TBSD_RSP_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link to the card
  tbsd_link_if.reader link
);
  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = sel[i] ? d[i*8 +: 8] : old[i*8 +: 8];
  endfunction : merge

  tbsd_rdr_state_t state;
  logic [31:0] ctrl;
  logic [31:0] pupi;
  logic [31:0] param;
  logic [31:0] appd;
  logic [3:0] idx;
  logic [31:0] tmo;
  logic answered;
  logic timed_out;
  logic [7:0] ans;

  // bus decode
  wire logic acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr = acc & wb_we_i;
  wire logic start = wr && wb_adr_i == `TBSD_REG_CTRL
    && wb_sel_i[0] && wb_dat_i[`TBSD_CTRL_START_BIT]
    && state == tbsd_r_idle;
  wire logic [31:0] stat = {16'h0000, ans, 5'd0, timed_out, answered,
    state != tbsd_r_idle};
  wire logic [31:0] rd_mux =
    wb_adr_i == `TBSD_REG_CTRL ? ctrl :
    wb_adr_i == `TBSD_REG_PUPI ? pupi :
    wb_adr_i == `TBSD_REG_PARAM ? param :
    wb_adr_i == `TBSD_REG_APPD ? appd :
    wb_adr_i == `TBSD_REG_STAT ? stat : 32'h0000_0000;

  // outgoing frame; reserved bits cleared
  wire logic use_f4 = ctrl[`TBSD_CTRL_F4_BIT];
  wire logic [3:0] last_idx = use_f4 ? 4'd13 : 4'd8;
  wire logic [7:0] p1 = {param[31:26], 2'b00};
  wire logic [7:0] p3 = {4'h0, param[11:8]};
  wire logic [7:0] p4 = {4'h0, param[3:0]};
  wire logic [7:0] tx_byte =
    idx == 4'd0 ? `TBSD_CMD_ATTRIB :
    idx <= 4'd4 ? pupi[(4'd4 - idx)*8 +: 8] :
    idx == 4'd5 ? p1 :
    idx == 4'd6 ? param[23:16] :
    idx == 4'd7 ? p3 :
    idx == 4'd8 ? p4 :
    idx == 4'd9 ? `TBSD_INF_MATCH :
    appd[(4'd13 - idx)*8 +: 8];

  // register file and bus answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= `TBSD_CTRL_RESET;
      pupi <= 32'h0000_0000;
      param <= 32'h0000_0000;
      appd <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc;
      wb_dat_o <= acc ? rd_mux : 32'h0000_0000;
      if (wr && wb_adr_i == `TBSD_REG_CTRL)
        ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_0006;
      if (wr && wb_adr_i == `TBSD_REG_PUPI)
        pupi <= merge(pupi, wb_dat_i, wb_sel_i);
      if (wr && wb_adr_i == `TBSD_REG_PARAM)
        param <= merge(param, wb_dat_i, wb_sel_i);
      if (wr && wb_adr_i == `TBSD_REG_APPD)
        appd <= merge(appd, wb_dat_i, wb_sel_i);
    end
  end

  // transfer sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= tbsd_r_idle;
      idx <= 4'd0;
      tmo <= 32'd0;
      answered <= 1'b0;
      timed_out <= 1'b0;
      ans <= 8'h00;
      link.cmd_valid <= 1'b0;
      link.cmd_data <= 8'h00;
      link.cmd_last <= 1'b0;
      link.cmd_crc_ok <= 1'b0;
    end
    else
    begin
      link.cmd_valid <= (state == tbsd_r_send);
      link.cmd_data <= (state == tbsd_r_send) ? tx_byte : 8'h00;
      link.cmd_last <= (state == tbsd_r_send) && idx == last_idx;
      link.cmd_crc_ok <= (state == tbsd_r_send) && idx == last_idx
        && !ctrl[`TBSD_CTRL_BADCRC_BIT];
      case (state)
        tbsd_r_idle:
          if (start)
          begin
            state <= tbsd_r_send;
            idx <= 4'd0;
            answered <= 1'b0;
            timed_out <= 1'b0;
          end
        tbsd_r_send:
          if (idx == last_idx)
          begin
            state <= tbsd_r_wait;
            tmo <= 32'(RSP_WAIT_CYC);
          end
          else
            idx <= idx + 4'd1;
        tbsd_r_wait:
          if (link.rsp_valid)
          begin
            ans <= link.rsp_data;
            answered <= 1'b1;
            state <= tbsd_r_idle;
          end
          else if (tmo == 32'd0)
          begin
            timed_out <= 1'b1;
            state <= tbsd_r_idle;
          end
          else
            tmo <= tmo - 32'd1;
        default:
          state <= tbsd_r_idle;
      endcase
    end
  end
endmodule : tbsd_reader

// ---- tbsd_link_sva.sv ----
// Purpose: checks the attrib exchange on the reader to card link
// Assumes: card built with default guard counts of at least 4 + 4 cycles
// Notes: instantiated beside the link interface, no bind
`timescale 1ns/1ps
module tbsd_link_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // reader to card
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  input wire logic cmd_crc_ok,
  // card to reader
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  logic [4:0] idx;
  logic may_ans;
  logic [3:0] cid_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // byte position in frame, answer permission, requested cid
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx <= 5'h00;
      may_ans <= 1'b0;
      cid_q <= 4'h0;
    end
    else
    begin
      if (cmd_valid)
        idx <= cmd_last ? 5'h00 : idx + 5'h01;
      if (cmd_valid)
        may_ans <= cmd_last && cmd_crc_ok;
      else if (rsp_valid)
        may_ans <= 1'b0;
      if (cmd_valid && idx == 5'h08)
        cid_q <= cmd_data[3:0];
    end
  end

  // the card keeps quiet for at least the shortest guard
  sequence s_quiet;
    (!rsp_valid)[*8];
  endsequence
  // the answer is one byte, then the line goes idle
  sequence s_one_byte;
    rsp_last ##1 (!rsp_valid && !rsp_last);
  endsequence

  property p_first_byte;
    cmd_valid && idx == 5'h00 |-> cmd_data == 8'h1d;
  endproperty
  a_first_byte: assert property (p_first_byte)
    else $error("frame does not open with the attrib command byte");
  property p_frame_len;
    cmd_last |-> cmd_valid && (idx == 5'h08 || idx == 5'h0d);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("attrib frame has a wrong byte count");
  property p_p1_rfu;
    cmd_valid && idx == 5'h05 |-> cmd_data[1:0] == 2'b00;
  endproperty
  a_p1_rfu: assert property (p_p1_rfu)
    else $error("param1 spare bits not zero");
  property p_p3_upper;
    cmd_valid && idx == 5'h07 |-> cmd_data[7:4] == 4'h0;
  endproperty
  a_p3_upper: assert property (p_p3_upper)
    else $error("param3 upper nibble not zero");
  property p_p4_upper;
    cmd_valid && idx == 5'h08 |-> cmd_data[7:4] == 4'h0;
  endproperty
  a_p4_upper: assert property (p_p4_upper)
    else $error("param4 upper nibble not zero");
  property p_inf_tag;
    cmd_valid && idx == 5'h09 |-> cmd_data == 8'hf4;
  endproperty
  a_inf_tag: assert property (p_inf_tag)
    else $error("inf field is not the matching form");
  property p_rsp_cause;
    rsp_valid |-> may_ans;
  endproperty
  a_rsp_cause: assert property (p_rsp_cause)
    else $error("answer without a good frame before it");
  property p_rsp_unit;
    rsp_valid |-> s_one_byte;
  endproperty
  a_rsp_unit: assert property (p_rsp_unit)
    else $error("answer is not a single byte");
  property p_rsp_cid;
    rsp_valid |-> rsp_data == {4'h0, cid_q};
  endproperty
  a_rsp_cid: assert property (p_rsp_cid)
    else $error("answer byte does not carry the assigned cid");
  property p_guard;
    cmd_last |=> s_quiet;
  endproperty
  a_guard: assert property (p_guard)
    else $error("answer before the minimum guard");
endmodule : tbsd_link_sva

// ---- testbench.sv ----
// Purpose: drives reader registers over wishbone, watches the card
// Assumes: guard defaults shrunk to 4 cycles, reader wait 8000 cycles
// Notes: the card returns to ready-declared only through reset
`timescale 1ns/1ps
`include "tbsd_defines.svh"
module testbench
  import tbsd_pkg::*;
;
  localparam logic [31:0] PUPI = 32'h1234_5678;
  localparam logic [31:0] APPD = 32'h9abc_def0;
  localparam logic [8:0] FSZ [9] = '{9'h010, 9'h018, 9'h020, 9'h028,
    9'h030, 9'h040, 9'h060, 9'h080, 9'h100};
  localparam logic [31:0] RJ_ID [5] = '{32'h1234_5679, PUPI, PUPI, PUPI, PUPI};
  localparam logic [31:0] RJ_PRM [5] = '{32'h0300_0103, 32'h0000_0103,
    32'h0000_0103, 32'h0000_0203, 32'h0000_010f};
  localparam logic [2:0] RJ_CTL [5] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h0};
  localparam logic [31:0] AC_PRM [4] = '{32'h0000_0100, 32'h5c58_010e,
    32'ha4f5_0107, 32'hf829_0103};
  localparam logic [2:0] AC_CTL [4] = '{3'h0, 3'h0, 3'h2, 3'h0};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, atqb_info_o;
  logic [31:0] wb_dat_i, wb_dat_o, pupi_i, app_data_i, rd, st;
  logic [3:0] wb_sel_i, cid_o;
  logic sof_opt_o, eof_opt_o, hl_frame_o;
  logic [1:0] pcd_rate_o, picc_rate_o;
  logic [8:0] fsd_bytes_o;
  tbsd_card_state_t state_o;
  int n_errors, n_checks;
  int n_hl;

  // both ends joined across the link, checker beside it
  tbsd_link_if tbsd_link_if_inst ();
  tbsd_reader #(.RSP_WAIT_CYC(8000)) tbsd_reader_inst (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .link(tbsd_link_if_inst));
  tbsd_card #(.TR0_DEF_CYC(4), .TR1_DEF_CYC(4)) tbsd_card_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link(tbsd_link_if_inst),
    .pupi_i(pupi_i), .app_data_i(app_data_i), .atqb_info_o(atqb_info_o),
    .state_o(state_o), .cid_o(cid_o), .sof_opt_o(sof_opt_o),
    .eof_opt_o(eof_opt_o), .pcd_rate_o(pcd_rate_o),
    .picc_rate_o(picc_rate_o), .fsd_bytes_o(fsd_bytes_o),
    .hl_frame_o(hl_frame_o));
  tbsd_link_sva tbsd_link_sva_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_valid(tbsd_link_if_inst.cmd_valid),
    .cmd_data(tbsd_link_if_inst.cmd_data),
    .cmd_last(tbsd_link_if_inst.cmd_last),
    .cmd_crc_ok(tbsd_link_if_inst.cmd_crc_ok),
    .rsp_valid(tbsd_link_if_inst.rsp_valid),
    .rsp_data(tbsd_link_if_inst.rsp_data),
    .rsp_last(tbsd_link_if_inst.rsp_last));

  // 40 mhz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // comparison with error count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic wishbone cycle, held until ack is sampled
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task do_reset;
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : do_reset

  // program one attrib, start it and poll until the reader is idle
  task attrib(input logic [31:0] id, input logic [31:0] prm,
    input logic [31:0] ad, input logic [2:0] ctl, output logic [31:0] s);
    logic [31:0] q;
    wb(1'b1, `TBSD_REG_PUPI, id, q);
    wb(1'b1, `TBSD_REG_PARAM, prm, q);
    wb(1'b1, `TBSD_REG_APPD, ad, q);
    wb(1'b1, `TBSD_REG_CTRL, {29'h0, ctl | 3'h1}, q);
    do
    begin
      wb(1'b0, `TBSD_REG_STAT, 32'h0, s);
    end
    while (s[0] !== 1'b0);
  endtask : attrib

  // settings the card should latch from a parameter word
  function automatic logic [31:0] exp_of(input logic [31:0] p);
    logic [8:0] fs;
    fs = (p[19:16] < 4'h9) ? FSZ[p[19:16]] : 9'h000;
    return {13'h0, p[3:0], p[26], p[27], p[21:20], p[23:22], fs};
  endfunction : exp_of

  task results;
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // main sequence
  initial
  begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    pupi_i = PUPI;
    app_data_i = APPD;
    n_errors = 0;
    n_checks = 0;
    n_hl = 0;
    do_reset();
    chk({24'h0, atqb_info_o}, {24'h0, `TBSD_FWI_DEFAULT, 4'h1});
    chk({30'h0, state_o}, {30'h0, tbsd_ready});
    wb(1'b1, 8'h14, 32'hffff_ffff, rd);
    wb(1'b0, 8'h14, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b0, `TBSD_REG_CTRL, 32'h0, rd);
    chk(rd, `TBSD_CTRL_RESET);
    $display("test reset done");
    // foreign id, bad crc, f4 mismatch, bad protocol type, cid 15
    for (int i = 0; i < 5; i++)
    begin
      attrib(RJ_ID[i], RJ_PRM[i], APPD ^ {21'h0, RJ_CTL[i][1], 10'h0},
        RJ_CTL[i], st);
      chk({29'h0, st[2:0]}, 32'h4);
      chk({30'h0, state_o}, {30'h0, tbsd_ready});
    end
    $display("test refusals done");
    // accepted attribs, with and without the f4 check
    for (int i = 0; i < 4; i++)
    begin
      do_reset();
      attrib(PUPI, AC_PRM[i], APPD, AC_CTL[i], st);
      chk({16'h0, st[15:8], 5'h0, st[2:0]},
        {20'h0, AC_PRM[i][3:0], 8'h02});
      chk({30'h0, state_o}, {30'h0, tbsd_active});
      chk({13'h0, cid_o, sof_opt_o, eof_opt_o, pcd_rate_o, picc_rate_o,
        fsd_bytes_o}, exp_of(AC_PRM[i]));
    end
    $display("test accepts done");
    // a second attrib while active is not answered
    attrib(PUPI, 32'h0000_0105, APPD, 3'h0, st);
    chk({29'h0, st[2:0]}, 32'h4);
    chk({28'h0, cid_o}, 32'h3);
    chk(n_hl, 32'h0);
    // a frame whose second byte names cid 3 reaches the higher layer
    attrib(32'h1300_0000, 32'h0000_0105, APPD, 3'h0, st);
    chk({29'h0, st[2:0]}, 32'h4);
    chk(n_hl, 32'h1);
    $display("test active done");
    results();
  end

  // count higher-layer frames accepted by the active card
  always @(posedge clk_i)
  begin
    if (hl_frame_o === 1'b1)
      n_hl++;
  end

  // watchdog: about 63000 cycles expected, cut at 100000
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    results();
  end
endmodule : testbench
